// ---- pkg/ct_alarm_defines.vh ----
`ifndef CT_ALARM_DEFINES_VH
`define CT_ALARM_DEFINES_VH

// =====================================================================
// Register byte offsets.
// =====================================================================
`define OFS_CTRL       8'h00
`define OFS_RANGE      8'h04
`define OFS_LOW_TH     8'h08
`define OFS_LEAK_TH    8'h0c
`define OFS_OVER_TH    8'h10
`define OFS_HYST       8'h14
`define OFS_ACK        8'h18
`define OFS_CURRENT    8'h1c
`define OFS_ALARM      8'h20
`define OFS_IRQ_STAT   8'h24
`define OFS_IRQ_MASK   8'h28

// =====================================================================
// Field positions and encodings.
// =====================================================================
`define CTRL_EN_BIT    0
`define CTRL_LAT_LO    1
`define LAT_NONE       2'h0
`define LAT_AUTO       2'h1
`define LAT_MAN        2'h2

// =====================================================================
// Reset values and limits (tenths of an amp for range).
// =====================================================================
`define RANGE_MAX      16'h03e8
`define RANGE_RST      16'h03e8
`define HYST_MAX       3'h5
`define HYST_RST       3'h2
`define TH_OFF         16'h0000
`endif

// ---- src/load_current_alarm_monitor.v ----
`timescale 1ns/10ps
`include "ct_alarm_defines.vh"

// =====================================================================
// Current transformer alarm monitor with AXI4-Lite registers.
// =====================================================================
module load_current_alarm_monitor (
  input  wire        core_clk,
  input  wire        sys_rst,
  input  wire        heatOutputOn,
  input  wire [15:0] sampleValue,
  input  wire        sampleValid,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         lowLoadAlarmFlag,
  output reg         leakage_alarm_flag,
  output reg         overcurrent_alarm_flag,
  output reg         irqOut
);

  // Configuration registers.
  reg        monitor_enable_reg;         // Monitoring enable.
  reg [1:0]  alarm_latch_mode_reg;       // Latch mode encoding.
  reg [15:0] transformer_full_scale_reg; // Range in tenths.
  reg [15:0] low_load_threshold_reg;     // Low-load threshold.
  reg [15:0] leakage_threshold_reg;      // Leakage threshold.
  reg [15:0] overcurrent_threshold_reg;  // Over-current threshold.
  reg [2:0]  hystPct_reg;                // Hysteresis percent.
  reg [15:0] loadCurrent_reg;            // Last load-current sample.
  reg [15:0] leakage_current_value_reg;  // Last leakage sample.
  reg [2:0]  cond_reg;                   // Raw conditions with hysteresis.
  reg [2:0]  ackSeen_reg;                // Acknowledge seen while latched.
  reg [2:0]  irqStat_reg;                // Sticky event bits.
  reg [2:0]  irqMask_reg;                // Interrupt mask.
  reg        awHeld_reg;                 // Write address captured.
  reg        wHeld_reg;                  // Write data captured.
  reg [7:0]  awAddr_reg;                 // Captured write address.
  reg [31:0] wData_reg;                  // Captured write data.
  reg [3:0]  wStrb_reg;                  // Captured strobes.

  // Hysteresis margin = range * pct / 100; the quotient never needs more than 16 bits.
  wire [18:0] rangePct   = transformer_full_scale_reg * hystPct_reg;
  wire [18:0] marginWide = rangePct / 19'd100;  // Full-width quotient.
  wire [15:0] hystMargin = marginWide[15:0];

  // Merge strobed bytes into an old value.
  function [31:0] mergeBytes;
    input [31:0] oldV;
    input [31:0] newV;
    input [3:0]  strb;
    integer i;
    begin
      mergeBytes = oldV;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          mergeBytes[i*8 +: 8] = newV[i*8 +: 8];
        end
      end
    end
  endfunction

  // Known-register decode, used by both channels.
  function isMapped;
    input [7:0] a;
    begin
      isMapped = (a[1:0] == 2'h0) && (a <= `OFS_IRQ_MASK);
    end
  endfunction

  // Strobe-merged views of the words that honour byte strobes.
  wire [31:0] ctrlMerged  = mergeBytes({29'h0, alarm_latch_mode_reg, monitor_enable_reg},
                                       wData_reg, wStrb_reg);
  wire [31:0] rangeMerged = mergeBytes({16'h0, transformer_full_scale_reg}, wData_reg, wStrb_reg);

  // =====================================================================
  // Alarm condition evaluation.
  // =====================================================================
  wire [2:0] flagsNow = {overcurrent_alarm_flag, leakage_alarm_flag, lowLoadAlarmFlag};
  wire        doWrite  = awHeld_reg && wHeld_reg && !s_axi_bvalid;
  wire        ackWrite = doWrite && (awAddr_reg == `OFS_ACK) && wStrb_reg[0] && wData_reg[0];
  wire [15:0] lastCur  = heatOutputOn ? loadCurrent_reg : leakage_current_value_reg;
  wire [16:0] lowExit  = {1'b0, low_load_threshold_reg} + {1'b0, hystMargin};
  wire [2:0]  condNext;
  // An ack is remembered while the flag stands, so it may come before the clear.
  wire [2:0]  ackNow    = ackSeen_reg | {3{ackWrite}};       // Acks seen so far.
  wire [2:0]  autoFlags = condNext | (flagsNow & ~ackNow);   // Auto-latch next flags.
  // Entry uses the bare threshold; exit needs the margin.
  assign condNext[0] = (low_load_threshold_reg != `TH_OFF) &&
                       (cond_reg[0] ? ({1'b0, loadCurrent_reg} < lowExit)
                                    : (loadCurrent_reg < low_load_threshold_reg));
  assign condNext[1] = (leakage_threshold_reg != `TH_OFF) &&
                       (cond_reg[1] ? ({1'b0, leakage_current_value_reg} + {1'b0, hystMargin} >
                                       {1'b0, leakage_threshold_reg})
                                    : (leakage_current_value_reg >
                                       leakage_threshold_reg));
  assign condNext[2] = (overcurrent_threshold_reg != `TH_OFF) &&
                       (cond_reg[2] ? ({1'b0, lastCur} + {1'b0, hystMargin} >
                                       {1'b0, overcurrent_threshold_reg})
                                    : (lastCur > overcurrent_threshold_reg));

  // Sampling and alarm state process.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      loadCurrent_reg           <= 16'h0000;
      leakage_current_value_reg <= 16'h0000;
      cond_reg                  <= 3'h0;
      ackSeen_reg               <= 3'h0;
      lowLoadAlarmFlag          <= 1'b0;
      leakage_alarm_flag        <= 1'b0;
      overcurrent_alarm_flag    <= 1'b0;
    end else if (!monitor_enable_reg) begin
      // Disabled monitoring drops every alarm, condition and ack, and holds the samples.
      cond_reg               <= 3'h0;
      ackSeen_reg            <= 3'h0;
      lowLoadAlarmFlag       <= 1'b0;
      leakage_alarm_flag     <= 1'b0;
      overcurrent_alarm_flag <= 1'b0;
    end else begin
      // Route the sample by output state.
      if (sampleValid && heatOutputOn) begin
        loadCurrent_reg <= sampleValue;
      end else if (sampleValid) begin
        leakage_current_value_reg <= sampleValue;
      end
      cond_reg <= condNext;
      // Latching per mode; acknowledge covers all three.
      case (alarm_latch_mode_reg)
        `LAT_AUTO: begin
          // Release needs a clear condition and an ack, in either order.
          ackSeen_reg <= ackNow & autoFlags;
          {overcurrent_alarm_flag, leakage_alarm_flag, lowLoadAlarmFlag} <=
            autoFlags;
        end
        `LAT_MAN: begin
          // Held until ack; ack while condition active is ignored.
          ackSeen_reg <= 3'h0;
          {overcurrent_alarm_flag, leakage_alarm_flag, lowLoadAlarmFlag} <=
            condNext | (flagsNow & ~{3{ackWrite}});
        end
        default: begin
          ackSeen_reg <= 3'h0;
          {overcurrent_alarm_flag, leakage_alarm_flag, lowLoadAlarmFlag} <= condNext;
        end
      endcase
    end
  end

  // =====================================================================
  // Interrupt status, mask and output.
  // =====================================================================
  reg  [2:0] cond_prev; // Flags one cycle earlier.
  wire       rdTake   = s_axi_arvalid && s_axi_arready;
  wire [2:0] riseEv   = {overcurrent_alarm_flag, leakage_alarm_flag, lowLoadAlarmFlag} &
                        ~cond_prev;

  // Sticky bits; a set in the clear cycle wins.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      cond_prev   <= 3'h0;
      irqStat_reg <= 3'h0;
      irqOut      <= 1'b0;
    end else begin
      cond_prev <= flagsNow;
      if (rdTake && s_axi_araddr == `OFS_IRQ_STAT) begin
        irqStat_reg <= riseEv;
      end else begin
        irqStat_reg <= irqStat_reg | riseEv;
      end
      irqOut <= |((irqStat_reg | riseEv) & irqMask_reg);
    end
  end

  // =====================================================================
  // AXI4-Lite write channel.
  // =====================================================================
  // Captures address and data in either order, then writes once.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      s_axi_awready              <= 1'b1;
      s_axi_wready               <= 1'b1;
      s_axi_bvalid               <= 1'b0;
      s_axi_bresp                <= 2'h0;
      awHeld_reg                 <= 1'b0;
      wHeld_reg                  <= 1'b0;
      awAddr_reg                 <= 8'h00;
      wData_reg                  <= 32'h00000000;
      wStrb_reg                  <= 4'h0;
      monitor_enable_reg         <= 1'b0;
      alarm_latch_mode_reg       <= `LAT_NONE;
      transformer_full_scale_reg <= `RANGE_RST;
      low_load_threshold_reg     <= `TH_OFF;
      leakage_threshold_reg      <= `TH_OFF;
      overcurrent_threshold_reg  <= `TH_OFF;
      hystPct_reg                <= `HYST_RST;
      irqMask_reg                <= 3'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_reg    <= s_axi_awaddr;
        awHeld_reg    <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_reg    <= s_axi_wdata;
        wStrb_reg    <= s_axi_wstrb;
        wHeld_reg    <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= isMapped(awAddr_reg) ? 2'h0 : 2'h2;
        // Settings other than enable are locked while disabled.
        if (awAddr_reg == `OFS_CTRL && monitor_enable_reg) begin
          // Enabled: enable and latch mode both follow the strobed bytes.
          {alarm_latch_mode_reg, monitor_enable_reg} <= ctrlMerged[2:0];
        end else if (awAddr_reg == `OFS_CTRL) begin
          // Disabled: only the enable bit may change.
          if (wStrb_reg[0]) begin
            monitor_enable_reg <= wData_reg[0];
          end
        end else if (monitor_enable_reg) begin
          case (awAddr_reg)
            `OFS_RANGE: begin
              // The whole merged word is range-checked so high bits cannot alias.
              if (rangeMerged <= {16'h0, `RANGE_MAX}) begin
                transformer_full_scale_reg <= rangeMerged[15:0];
              end
            end
            `OFS_LOW_TH: begin
              if (wData_reg <= {16'h0, `RANGE_MAX}) begin
                low_load_threshold_reg <= wData_reg[15:0];
              end
            end
            `OFS_LEAK_TH: begin
              if (wData_reg <= {16'h0, `RANGE_MAX}) begin
                leakage_threshold_reg <= wData_reg[15:0];
              end
            end
            `OFS_OVER_TH: begin
              if (wData_reg <= {16'h0, `RANGE_MAX}) begin
                overcurrent_threshold_reg <= wData_reg[15:0];
              end
            end
            `OFS_HYST: begin
              if (wData_reg <= {29'h0, `HYST_MAX}) begin
                hystPct_reg <= wData_reg[2:0];
              end
            end
            `OFS_IRQ_MASK: begin
              irqMask_reg <= wData_reg[2:0];
            end
            default: begin
              irqMask_reg <= irqMask_reg;
            end
          endcase
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        awHeld_reg    <= 1'b0;
        wHeld_reg     <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // =====================================================================
  // AXI4-Lite read channel.
  // =====================================================================
  // Takes one read, answers the next cycle, holds until rready.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
    end else begin
      if (rdTake) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= isMapped(s_axi_araddr) ? 2'h0 : 2'h2;
        case (s_axi_araddr)
          `OFS_CTRL:     s_axi_rdata <= {29'h0, alarm_latch_mode_reg, monitor_enable_reg};
          `OFS_RANGE:    s_axi_rdata <= {16'h0, transformer_full_scale_reg};
          `OFS_LOW_TH:   s_axi_rdata <= {16'h0, low_load_threshold_reg};
          `OFS_LEAK_TH:  s_axi_rdata <= {16'h0, leakage_threshold_reg};
          `OFS_OVER_TH:  s_axi_rdata <= {16'h0, overcurrent_threshold_reg};
          `OFS_HYST:     s_axi_rdata <= {29'h0, hystPct_reg};
          `OFS_CURRENT:  s_axi_rdata <= {leakage_current_value_reg, loadCurrent_reg};
          `OFS_ALARM:    s_axi_rdata <= {29'h0, flagsNow};
          `OFS_IRQ_STAT: s_axi_rdata <= {29'h0, irqStat_reg};
          `OFS_IRQ_MASK: s_axi_rdata <= {29'h0, irqMask_reg};
          default:       s_axi_rdata <= 32'h00000000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // load_current_alarm_monitor

// ---- verif/ct_source_model.sv ----
`timescale 1ns/10ps
// =====================================================================
// Current transformer front end: delivers one reading per request.
// =====================================================================
module ct_source_model (
  input  wire logic        core_clk,
  input  wire logic        heatOutputOn,
  input  wire logic [15:0] loadAmps,
  input  wire logic [15:0] leakAmps,
  input  wire logic        takeSample,
  output logic      [15:0] sampleValue,
  output logic             sampleValid
);
  logic [15:0] lastReg;  // Last reading, inverted on the bus between readings.

  initial begin
    sampleValue = 16'h0000;
    sampleValid = 1'b0;
    lastReg = 16'h0000;
  end

  // The transformer sees load current while heating, leakage otherwise.
  always @(posedge core_clk) begin
    sampleValid <= takeSample;
    if (takeSample) begin
      sampleValue <= heatOutputOn ? loadAmps : leakAmps;
      lastReg <= heatOutputOn ? loadAmps : leakAmps;
    end else begin
      sampleValue <= ~lastReg;
    end
  end
endmodule  // ct_source_model

// ---- verif/load_current_alarm_monitor_assertions.sv ----
`timescale 1ns/10ps
// =====================================================================
// Port checks of the alarm monitor.
// =====================================================================
module lcam_checker (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        sampleValid,
  input wire logic        heatOutputOn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        lowLoadAlarmFlag,
  input wire logic        leakage_alarm_flag,
  input wire logic        overcurrent_alarm_flag
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  aw_block_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address taken twice");
  b_order_a: assert property ($rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready)
    else $error("answer before write taken");
  b_release_a: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write not closed");
  r_code_a: assert property (s_axi_rvalid |-> s_axi_rresp == 2'b00 || s_axi_rresp == 2'b10)
    else $error("bad read code");
  flag_quiet_a: assert property ((!sampleValid && !s_axi_wvalid && $stable(heatOutputOn)) [*6] |=>
    $stable({lowLoadAlarmFlag, leakage_alarm_flag, overcurrent_alarm_flag}))
    else $error("flag moved without cause");
endmodule  // lcam_checker

bind load_current_alarm_monitor lcam_checker i_lcam_checker (.core_clk, .sys_rst,
  .sampleValid, .heatOutputOn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .lowLoadAlarmFlag,
  .leakage_alarm_flag, .overcurrent_alarm_flag);

// ---- verif/load_current_alarm_monitor_bench.sv ----
`timescale 1ns/10ps
`include "ct_alarm_defines.vh"
// =====================================================================
// Self-checking bench of the alarm monitor.
// =====================================================================
module load_current_alarm_monitor_bench;
  logic        core_clk, sys_rst, heatOutputOn, takeSample;
  logic [15:0] loadAmps, leakAmps, sampleValue;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        sampleValid, lowLoadAlarmFlag, leakage_alarm_flag, overcurrent_alarm_flag;
  logic        irqOut;
  integer      n_fail, checks;
  wire  [2:0]  flags = {overcurrent_alarm_flag, leakage_alarm_flag, lowLoadAlarmFlag};

  load_current_alarm_monitor i_load_current_alarm_monitor (.core_clk, .sys_rst,
    .heatOutputOn, .sampleValue, .sampleValid, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .lowLoadAlarmFlag, .leakage_alarm_flag, .overcurrent_alarm_flag, .irqOut);
  ct_source_model i_ct_source_model (.core_clk, .heatOutputOn, .loadAmps, .leakAmps,
    .takeSample, .sampleValue, .sampleValid);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Verdict and end of run.
  task test_done;
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("BAD %0s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Write one word; each channel drops its valid at the edge where it is taken.
  task wr(input logic [7:0] a, input logic [31:0] d);
    integer k;
    logic bOk;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    bOk = 1'b0;
    for (k = 0; k < 40 && !bOk; k = k + 1) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        bOk = 1'b1;
        s_axi_bready <= 1'b0;
      end
    end
    if (!bOk) begin
      n_fail = n_fail + 1;
      test_done();
    end
    chk("bresp", {30'h0, s_axi_bresp}, 32'h0);
  endtask

  // Read one word and compare the bits under m and the response code.
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    integer k;
    logic rOk;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    rOk = 1'b0;
    for (k = 0; k < 40 && !rOk; k = k + 1) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rOk = 1'b1;
        s_axi_rready <= 1'b0;
      end
    end
    if (!rOk) begin
      n_fail = n_fail + 1;
      test_done();
    end
    chk("rdata", s_axi_rdata & m, e);
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  // One transformer reading, then the three flags {over, leak, low}.
  task samp(input logic on, input logic [15:0] ld, input logic [15:0] lk, input logic [2:0] e);
    @(posedge core_clk);
    heatOutputOn <= on;
    loadAmps <= ld;
    leakAmps <= lk;
    takeSample <= 1'b1;
    @(posedge core_clk);
    takeSample <= 1'b0;
    repeat (5) @(posedge core_clk);
    chk("flags", {29'h0, flags}, {29'h0, e});
  endtask

  // Reset values, refused address, locked settings and limits.
  task t_setup;
    rd(`OFS_CTRL, 32'hffffffff, 32'h0, 2'b00);
    rd(`OFS_RANGE, 32'hffff, {16'h0, `RANGE_RST}, 2'b00);
    rd(`OFS_HYST, 32'hffff, {29'h0, `HYST_RST}, 2'b00);
    rd(`OFS_LOW_TH, 32'hffff, 32'h0, 2'b00);
    rd(8'h40, 32'hffffffff, 32'h0, 2'b10);
    wr(`OFS_LOW_TH, 32'd300);
    rd(`OFS_LOW_TH, 32'hffff, 32'h0, 2'b00);
    wr(`OFS_CTRL, 32'h1);
    wr(`OFS_RANGE, 32'd1001);
    rd(`OFS_RANGE, 32'hffff, 32'd1000, 2'b00);
    wr(`OFS_HYST, 32'd6);
    rd(`OFS_HYST, 32'hffff, 32'd2, 2'b00);
  endtask

  // Thresholds and the 20-unit exit margin (2 percent of 1000).
  task t_levels;
    wr(`OFS_LOW_TH, 32'd200);
    wr(`OFS_LEAK_TH, 32'd50);
    wr(`OFS_OVER_TH, 32'd800);
    samp(1'b1, 16'd100, 16'd0, 3'b001);
    samp(1'b1, 16'd210, 16'd0, 3'b001);
    samp(1'b1, 16'd300, 16'd0, 3'b000);
    samp(1'b0, 16'd0, 16'd60, 3'b010);
    samp(1'b0, 16'd0, 16'd0, 3'b000);
    samp(1'b1, 16'd900, 16'd0, 3'b100);
    samp(1'b1, 16'd790, 16'd0, 3'b100);
    samp(1'b1, 16'd700, 16'd0, 3'b000);
  endtask

  // Manual then automatic latching with the common acknowledge.
  task t_latch;
    wr(`OFS_CTRL, 32'h5);
    samp(1'b1, 16'd900, 16'd0, 3'b100);
    samp(1'b1, 16'd500, 16'd0, 3'b100);
    wr(`OFS_ACK, 32'h1);
    repeat (4) @(posedge core_clk);
    chk("flags", {29'h0, flags}, 32'h0);
    wr(`OFS_CTRL, 32'h3);
    samp(1'b1, 16'd900, 16'd0, 3'b100);
    wr(`OFS_ACK, 32'h1);
    repeat (4) @(posedge core_clk);
    chk("flags", {29'h0, flags}, 32'h4);
    samp(1'b1, 16'd500, 16'd0, 3'b000);
  endtask

  // Interrupt: masked event, unmask, clear by reading status.
  task t_irq;
    wr(`OFS_CTRL, 32'h1);
    wr(`OFS_IRQ_MASK, 32'h0);
    rd(`OFS_IRQ_STAT, 32'h7, 32'h7, 2'b00);
    samp(1'b1, 16'd900, 16'd0, 3'b100);
    chk("irq", {31'h0, irqOut}, 32'h0);
    wr(`OFS_IRQ_MASK, 32'hffff);
    repeat (3) @(posedge core_clk);
    chk("irq", {31'h0, irqOut}, 32'h1);
    rd(`OFS_IRQ_STAT, 32'h7, 32'h4, 2'b00);
    repeat (3) @(posedge core_clk);
    chk("irq", {31'h0, irqOut}, 32'h0);
  endtask

  initial begin
    n_fail = 0;
    checks = 0;
    sys_rst = 1'b1;
    heatOutputOn = 1'b0;
    takeSample = 1'b0;
    loadAmps = 16'h0000;
    leakAmps = 16'h0000;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_setup();
    t_levels();
    t_latch();
    t_irq();
    test_done();
  end
endmodule  // load_current_alarm_monitor_bench
